// ===== core/frl_programmer.sv
// flash row latch programmer: unlock, write latches, row commit and erase
module frl_programmer #(
  parameter int LATCH_COUNT = frl_pkg::LATCH_COUNT
) (
  input  wire logic                             core_clk,
  input  wire logic                             resetn,
  input  wire logic                             keyWrStb,
  input  wire logic [7:0]                       keyWrData,
  input  wire logic                             otherWrStb,
  input  wire logic                             startStb,
  input  wire logic                             writeEnable,
  input  wire logic                             latchOnlyMode,
  input  wire logic                             eraseSelect,
  input  wire logic                             regionSelect,
  input  wire logic                             writeProtected,
  input  wire logic [frl_pkg::ADDR_HIGH_W-1:0]  progAddrHigh,
  input  wire logic [frl_pkg::ADDR_LOW_W-1:0]   progAddrLow,
  input  wire logic [frl_pkg::DATA_HIGH_W-1:0]  progDataHigh,
  input  wire logic [7:0]                       progDataLow,
  input  wire logic                             flashAck,
  input  wire logic                             doneFlagClr,
  input  wire logic                             irqEnable,
  output logic                                  cpuStall,
  output logic                                  flashWrEn,
  output logic                                  flashEraseEn,
  output logic [frl_pkg::ROW_W-1:0]             flashRow,
  output logic [frl_pkg::IDX_W-1:0]             flashIdx,
  output logic [frl_pkg::WORD_W-1:0]            flashData,
  output logic                                  doneFlag,
  output logic                                  doneIrq
);
  import frl_pkg::*;

  // ************************************************************
  // reset release
  // ************************************************************
  logic rstSync1_r;
  logic rstn;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rstSync1_r <= 1'b0;
      rstn       <= 1'b0;
    end else begin
      rstSync1_r <= 1'b1;
      rstn       <= rstSync1_r;
    end
  end

  // ************************************************************
  // unlock sequence
  // ************************************************************
  frl_key_e key_r;
  frl_key_e key_nxt;
  always_comb begin
    key_nxt = key_r;
    // RULE15 exact key order
    if (keyWrStb) begin
      if (keyWrData == KEY_FIRST) key_nxt = FRL_K_FIRST;
      else if (keyWrData == KEY_SECOND && key_r == FRL_K_FIRST) key_nxt = FRL_K_SECOND;
      else key_nxt = FRL_K_IDLE;
    // RULE20 any other write breaks it
    end else if (otherWrStb || startStb) begin
      key_nxt = FRL_K_IDLE;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) key_r <= FRL_K_IDLE;
    else       key_r <= key_nxt;
  end

  // ************************************************************
  // start decode
  // ************************************************************
  frl_state_e        state_r;
  frl_state_e        state_nxt;
  logic [IDX_W-1:0]  idx_r;
  logic [IDX_W-1:0]  idx_nxt;
  logic [WORD_W-1:0] dataWord;
  logic [ROW_W-1:0]  addrRow;
  logic [IDX_W-1:0]  addrIdx;
  logic              startOk;
  logic              loadEn;
  logic              commitGo;
  logic              eraseGo;
  logic              blankAll;
  logic              opDone;

  assign dataWord = {progDataHigh, progDataLow};
  // RULE1 RULE14 address split
  assign addrRow  = {progAddrHigh, progAddrLow[ADDR_LOW_W-1:IDX_W]};
  assign addrIdx  = progAddrLow[IDX_W-1:0];
  // RULE11 RULE19 gated start
  assign startOk  = startStb && key_r == FRL_K_SECOND && writeEnable
                    && state_r == FRL_S_IDLE && !regionSelect;
  // RULE9 RULE10 latch load
  assign loadEn   = startOk && !eraseSelect;
  assign commitGo = loadEn && !latchOnlyMode;
  // RULE18 protected erase dropped
  assign eraseGo  = startOk && eraseSelect && !writeProtected;

  // ************************************************************
  // write latches
  // ************************************************************
  logic [WORD_W-1:0] latchQ [LATCH_COUNT];
  genvar g;
  generate
    for (g = 0; g < LATCH_COUNT; g++) begin : gLatch
      always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          latchQ[g] <= BLANK_WORD;
        // RULE4 RULE5 blank after operation
        end else if (blankAll) begin
          latchQ[g] <= BLANK_WORD;
        end else if (loadEn && addrIdx == IDX_W'(g)) begin
          latchQ[g] <= dataWord;
        end
      end
    end
  endgenerate

  // ************************************************************
  // sequencer
  // ************************************************************
  logic              cpuStall_nxt;
  logic              flashWrEn_nxt;
  logic              flashEraseEn_nxt;
  logic [ROW_W-1:0]  flashRow_nxt;
  logic [IDX_W-1:0]  flashIdx_nxt;
  logic [WORD_W-1:0] flashData_nxt;
  logic              doneFlag_nxt;
  logic              doneIrq_nxt;

  always_comb begin
    state_nxt        = state_r;
    idx_nxt          = idx_r;
    cpuStall_nxt     = cpuStall;
    flashWrEn_nxt    = 1'b0;
    flashEraseEn_nxt = 1'b0;
    flashRow_nxt     = flashRow;
    flashIdx_nxt     = flashIdx;
    flashData_nxt    = flashData;
    blankAll         = 1'b0;
    opDone           = 1'b0;
    case (state_r)
      FRL_S_IDLE: begin
        if (commitGo || eraseGo) begin
          // RULE2 row captured once per operation
          flashRow_nxt = addrRow;
          idx_nxt      = '0;
          // RULE16 stall cpu
          cpuStall_nxt = 1'b1;
          // RULE6 RULE8 program or erase, never both
          state_nxt    = commitGo ? FRL_S_PROG : FRL_S_ERASE;
        end
      end
      FRL_S_PROG: begin
        // RULE3 one word per latch
        flashWrEn_nxt = 1'b1;
        flashIdx_nxt  = idx_r;
        flashData_nxt = latchQ[idx_r];
        state_nxt     = FRL_S_PWAIT;
      end
      FRL_S_PWAIT: begin
        if (flashAck) begin
          if (idx_r == IDX_W'(LATCH_COUNT - 1)) begin
            opDone = 1'b1;
          end else begin
            idx_nxt   = idx_r + 1'b1;
            state_nxt = FRL_S_PROG;
          end
        end
      end
      FRL_S_ERASE: begin
        flashEraseEn_nxt = 1'b1;
        state_nxt        = FRL_S_EWAIT;
      end
      FRL_S_EWAIT: begin
        if (flashAck) opDone = 1'b1;
      end
      default: begin
        state_nxt = FRL_S_IDLE;
      end
    endcase
    if (opDone) begin
      blankAll     = 1'b1;
      cpuStall_nxt = 1'b0;
      state_nxt    = FRL_S_IDLE;
    end
  end

  // RULE17 flag on completion, set wins
  assign doneFlag_nxt = opDone || (doneFlag && !doneFlagClr);
  assign doneIrq_nxt  = doneFlag_nxt && irqEnable;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_r      <= FRL_S_IDLE;
      idx_r        <= '0;
      cpuStall     <= 1'b0;
      flashWrEn    <= 1'b0;
      flashEraseEn <= 1'b0;
      flashRow     <= '0;
      flashIdx     <= '0;
      flashData    <= BLANK_WORD;
      doneFlag     <= 1'b0;
      doneIrq      <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      idx_r        <= idx_nxt;
      cpuStall     <= cpuStall_nxt;
      flashWrEn    <= flashWrEn_nxt;
      flashEraseEn <= flashEraseEn_nxt;
      flashRow     <= flashRow_nxt;
      flashIdx     <= flashIdx_nxt;
      flashData    <= flashData_nxt;
      doneFlag     <= doneFlag_nxt;
      doneIrq      <= doneIrq_nxt;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  property p_rowSplit;
    $rose(cpuStall) |-> flashRow == $past(addrRow);
  endproperty
  a_rowSplit: assert property (p_rowSplit) else $error("row not from upper address"); // RULE1

  property p_rowHold;
    cpuStall && $past(cpuStall) |-> $stable(flashRow);
  endproperty
  a_rowHold: assert property (p_rowHold) else $error("row moved during operation"); // RULE2

  property p_blank;
    opDone |=> latchQ[0] == BLANK_WORD && latchQ[LATCH_COUNT-1] == BLANK_WORD;
  endproperty
  a_blank: assert property (p_blank) else $error("latches not blanked"); // RULE4

  property p_noErase;
    state_r inside {FRL_S_PROG, FRL_S_PWAIT} |-> !flashEraseEn;
  endproperty
  a_noErase: assert property (p_noErase) else $error("erase during commit"); // RULE6

  property p_eraseOnce;
    flashEraseEn |=> !flashEraseEn [*2];
  endproperty
  a_eraseOnce: assert property (p_eraseOnce) else $error("erase repeated"); // RULE8

  property p_latchOnly;
    loadEn && latchOnlyMode |=> !cpuStall && latchQ[$past(addrIdx)] == $past(dataWord);
  endproperty
  a_latchOnly: assert property (p_latchOnly) else $error("latch-only load wrong"); // RULE9

  property p_commit;
    commitGo |=> cpuStall ##1 flashWrEn && flashIdx == '0;
  endproperty
  a_commit: assert property (p_commit) else $error("commit did not start"); // RULE10

  property p_broken;
    startStb && key_r != FRL_K_SECOND && state_r == FRL_S_IDLE |=> !cpuStall && !flashWrEn;
  endproperty
  a_broken: assert property (p_broken) else $error("broken unlock accepted"); // RULE11

  property p_resume;
    opDone |=> !cpuStall && state_r == FRL_S_IDLE;
  endproperty
  a_resume: assert property (p_resume) else $error("stall not released"); // RULE16

  property p_flag;
    opDone |=> doneFlag ##1 (doneIrq == $past(irqEnable));
  endproperty
  a_flag: assert property (p_flag) else $error("done flag or irq wrong"); // RULE17

  property p_protect;
    startOk && eraseSelect && writeProtected |=> !cpuStall ##1 !flashEraseEn;
  endproperty
  a_protect: assert property (p_protect) else $error("protected row erased"); // RULE18

  property p_noEnable;
    startStb && !writeEnable && state_r == FRL_S_IDLE |=> !cpuStall;
  endproperty
  a_noEnable: assert property (p_noEnable) else $error("start without enable"); // RULE19

  property p_keyBreak;
    key_r == FRL_K_FIRST && otherWrStb && !keyWrStb |=> key_r == FRL_K_IDLE;
  endproperty
  a_keyBreak: assert property (p_keyBreak) else $error("key not broken"); // RULE20

  c_latchLoad: cover property (loadEn && latchOnlyMode);
  c_commitDone: cover property (state_r == FRL_S_PWAIT ##1 opDone);
  c_eraseDone: cover property (state_r == FRL_S_EWAIT && flashAck);
  c_protected: cover property (startOk && eraseSelect && writeProtected);

endmodule // frl_programmer

// ===== shared/frl_pkg.sv
// constants and types for the flash row latch programmer
//
// Contract
// RULE1: row from upper ten bits, latch from low five
// RULE2: one operation never leaves the selected row
// RULE3: commit programs up to thirty-two 14-bit latches
// RULE4: every write or erase blanks all latches
// RULE5: unloaded latches stay blank through a commit
// RULE6: commit programs only, never erases
// RULE7: software targets only erased or unwritten words
// RULE8: erase works on one whole row only
// RULE9: latch-only mode loads a latch, no programming
// RULE10: without latch-only, load last word then program row
// RULE11: broken unlock loads nothing, programs nothing
// RULE12: software loads latches, then clears latch-only, commits
// RULE13: software sets address, region, erase, enable, unlocks
// RULE14: address held as low byte plus high part
// RULE15: unlock is key 55h, key AAh, start
// RULE16: cpu stalled until the flash operation finishes
// RULE17: erase completion sets flag, irq if enabled
// RULE18: protected erase clears start, erases nothing
// RULE19: start ignored while write enable is clear
// RULE20: key AAh then start must follow directly
package frl_pkg;

  // ************************************************************
  // widths and values
  // ************************************************************
  localparam int          LATCH_COUNT  = 32;
  localparam int          WORD_W       = 14;
  localparam int          ADDR_HIGH_W  = 7;
  localparam int          ADDR_LOW_W   = 8;
  localparam int          IDX_W        = 5;
  localparam int          ROW_W        = 10;
  localparam int          DATA_HIGH_W  = 6;
  localparam logic [7:0]  KEY_FIRST    = 8'h55;
  localparam logic [7:0]  KEY_SECOND   = 8'haa;
  localparam logic [13:0] BLANK_WORD   = 14'h3fff;

  // ************************************************************
  // state encodings
  // ************************************************************
  typedef enum logic [2:0] {
    FRL_K_IDLE = 3'b001,
    FRL_K_FIRST = 3'b010,
    FRL_K_SECOND = 3'b100
  } frl_key_e;

  typedef enum logic [4:0] {
    FRL_S_IDLE  = 5'b00001,
    FRL_S_PROG  = 5'b00010,
    FRL_S_PWAIT = 5'b00100,
    FRL_S_ERASE = 5'b01000,
    FRL_S_EWAIT = 5'b10000
  } frl_state_e;

endpackage

// ===== verification/frl_programmer_tb_top.sv
// self-checking bench for the flash row latch programmer
module frl_programmer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import frl_pkg::*;
  // ********
  // signals
  // ********
  typedef struct packed {
    logic        erase;
    logic [9:0]  row;
    logic [4:0]  idx;
    logic [13:0] data;
  } frl_note_s;
  logic        core_clk = 0, resetn = 0, keyWrStb = 0, otherWrStb = 0, startStb = 0;
  logic        writeEnable = 1, latchOnlyMode = 0, eraseSelect = 0, regionSelect = 0;
  logic        writeProtected = 0, flashAck = 0, doneFlagClr = 0, irqEnable = 1;
  logic [7:0]  keyWrData = 8'h00, progAddrLow = 8'h00, progDataLow = 8'h00;
  logic [6:0]  progAddrHigh = 7'h00;
  logic [5:0]  progDataHigh = 6'h00;
  logic        cpuStall, flashWrEn, flashEraseEn, doneFlag, doneIrq;
  logic [9:0]  flashRow, r;
  logic [4:0]  flashIdx;
  logic [13:0] flashData;
  logic [13:0] lat [32];
  frl_note_s   expQ [$];
  frl_note_s   e;
  int          n_errors = 0, checks = 0, ackWait = 0;

  always #12.5 core_clk = ~core_clk;

  frl_programmer #(.LATCH_COUNT(32)) i_frl_programmer (
    .core_clk(core_clk), .resetn(resetn), .keyWrStb(keyWrStb), .keyWrData(keyWrData),
    .otherWrStb(otherWrStb), .startStb(startStb), .writeEnable(writeEnable),
    .latchOnlyMode(latchOnlyMode), .eraseSelect(eraseSelect), .regionSelect(regionSelect),
    .writeProtected(writeProtected), .progAddrHigh(progAddrHigh), .progAddrLow(progAddrLow),
    .progDataHigh(progDataHigh), .progDataLow(progDataLow), .flashAck(flashAck),
    .doneFlagClr(doneFlagClr), .irqEnable(irqEnable), .cpuStall(cpuStall),
    .flashWrEn(flashWrEn), .flashEraseEn(flashEraseEn), .flashRow(flashRow),
    .flashIdx(flashIdx), .flashData(flashData), .doneFlag(doneFlag), .doneIrq(doneIrq));

  // ********
  // tasks
  // ********
  task chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("ERROR %0t: %s", $time, msg);
    end
  endtask

  task end_of_test;
    if (n_errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task pulse(input int k, input logic [7:0] v);
    @(negedge core_clk);
    keyWrStb = (k == 0);
    keyWrData = v;
    otherWrStb = (k == 1);
    startStb = (k == 2);
    @(negedge core_clk);
    keyWrStb = 0;
    otherWrStb = 0;
    startStb = 0;
  endtask

  task unlock(input int brk);
    pulse(0, KEY_FIRST);
    if (brk == 1) pulse(1, 8'h00);
    if (brk == 2) pulse(0, 8'h12);
    pulse(0, KEY_SECOND);
    if (brk == 3) pulse(1, 8'h00);
    pulse(2, 8'h00);
  endtask

  task waitIdle;
    int n;
    n = 0;
    @(negedge core_clk);
    chk(cpuStall === 1'b1, "no stall");
    while (cpuStall !== 1'b0 && n < 1000) begin
      @(negedge core_clk);
      n++;
    end
    chk(n < 1000 && doneFlag === 1'b1, "operation end");
    @(negedge core_clk);
    chk(doneIrq === irqEnable, "interrupt level");
  endtask

  task clrFlag;
    @(negedge core_clk);
    doneFlagClr = 1;
    @(negedge core_clk);
    doneFlagClr = 0;
    @(negedge core_clk);
    chk(doneFlag === 1'b0 && doneIrq === 1'b0, "flag clear");
  endtask

  task load(input logic [9:0] row, input logic [4:0] idx, input logic [13:0] d,
            input logic lom, input int brk);
    @(negedge core_clk);
    {progAddrHigh, progAddrLow} = {row, idx};
    {progDataHigh, progDataLow} = d;
    latchOnlyMode = lom;
    eraseSelect = 0;
    unlock(brk);
    if (brk == 0 && writeEnable && !regionSelect) begin
      lat[idx] = d;
      if (!lom) begin
        for (int i = 0; i < 32; i++) expQ.push_back({1'b0, row, 5'(i), lat[i]});
        lat = '{default: BLANK_WORD};
        waitIdle();
      end
    end
  endtask

  task erase(input logic [9:0] row, input logic prot);
    @(negedge core_clk);
    {progAddrHigh, progAddrLow} = {row, 5'($urandom)};
    eraseSelect = 1;
    writeProtected = prot;
    unlock(0);
    if (prot) begin
      repeat (4) @(negedge core_clk);
      chk(cpuStall === 1'b0 && doneFlag === 1'b0, "protected erase");
    end else begin
      expQ.push_back({1'b1, row, 5'h00, 14'h0000});
      lat = '{default: BLANK_WORD};
      waitIdle();
    end
    eraseSelect = 0;
    writeProtected = 0;
  endtask

  // flash array answers each pulse after 1 to 4 cycles
  always @(negedge core_clk) begin
    if (flashWrEn === 1'b1 || flashEraseEn === 1'b1) ackWait = $urandom_range(1, 4);
    flashAck = (ackWait == 1);
    if (ackWait > 0) ackWait--;
  end

  // scoreboard: oldest note against each pulse
  always @(negedge core_clk) begin
    if (flashWrEn === 1'b1 || flashEraseEn === 1'b1) begin
      if (expQ.size() == 0) chk(1'b0, "unexpected flash pulse");
      else begin
        e = expQ.pop_front();
        chk(flashEraseEn === e.erase && flashWrEn === !e.erase && flashRow === e.row &&
            (e.erase || (flashIdx === e.idx && flashData === e.data)), "flash pulse");
      end
    end
  end

  // ********
  // stimulus
  // ********
  initial begin
    void'($urandom(47091));
    lat = '{default: BLANK_WORD};
    r = 10'($urandom);
    repeat (2) @(negedge core_clk);
    resetn = 1;
    repeat (3) @(negedge core_clk);
    chk(cpuStall === 1'b0 && flashData === BLANK_WORD && doneFlag === 1'b0, "reset");
    repeat (6) load(r, 5'($urandom), 14'($urandom), 1, 0);
    for (int b = 1; b < 4; b++) load(r, 5'($urandom), 14'($urandom), 1, b);
    writeEnable = 0;
    load(r, 5'($urandom), 14'($urandom), 1, 0);
    writeEnable = 1;
    regionSelect = 1;
    load(r, 5'($urandom), 14'($urandom), 1, 0);
    regionSelect = 0;
    load(r, 5'h1f, 14'($urandom), 0, 0);
    clrFlag();
    irqEnable = 0;
    load(r + 10'h001, 5'h00, 14'($urandom), 0, 0);
    clrFlag();
    irqEnable = 1;
    load(r, 5'h03, 14'($urandom), 1, 0);
    erase(r + 10'h002, 1);
    erase(r + 10'h002, 0);
    load(r + 10'h002, 5'h07, 14'($urandom), 0, 0);
    repeat (5) @(negedge core_clk);
    chk(expQ.size() == 0, "missing flash pulses");
    end_of_test();
  end

  initial begin
    #(25 * 20000);
    $display("ERROR %0t: timeout", $time);
    n_errors++;
    end_of_test();
  end
endmodule // frl_programmer_tb_top
